// file: pst_pkg.sv
package pst_pkg;

    // APB register offsets
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] TIMEDIAL_OFFSET  = 8'h04;
    localparam logic [7:0] PICKUP_OFFSET    = 8'h08;
    localparam logic [7:0] RELEASE_OFFSET   = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET    = 8'h10;
    localparam logic [7:0] DELAY_OFFSET     = 8'h14;
    localparam logic [7:0] COUNT_OFFSET     = 8'h18;
    localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h1C;
    localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h20;

    // Forced stage status
    typedef enum logic [1:0] {
        FORCE_NORMAL,
        FORCE_START,
        FORCE_TRIP,
        FORCE_BLOCKED
    } pst_force_e;

    // Control register layout, top bit first
    typedef struct packed {
        pst_force_e forceState;
        logic       forceEnable;
        logic       curveLog;
        logic       continueCalc;
        logic       resetAfterRelease;
        logic       delayedRelease;
    } pst_ctrl_s;

    // Event bits for interrupt status and mask
    typedef struct packed {
        logic releaseEnd;
        logic tripRise;
        logic startRise;
    } pst_irq_s;

    // Values after reset
    localparam logic [6:0]  CTRL_RESET     = 7'h03;
    localparam logic [15:0] TIMEDIAL_RESET = 16'h03E8;
    localparam logic [15:0] PICKUP_RESET   = 16'h0064;
    localparam logic [15:0] RELEASE_RESET  = 16'h000C;
    localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

    // Curve coefficients in thousandths (ln 2 in millionths, log slope in ms per doubling of the ratio), delays in ms
    localparam int MECH_A_MILLI   = 339;
    localparam int MECH_B_MILLI   = 236;
    localparam int LOG_A_MS       = 5800;
    localparam int LOG_B_MILLI    = 1350;
    localparam int LN2_MICRO      = 693147;
    localparam int LOG_SLOPE_Q8   = (LOG_B_MILLI * LN2_MICRO) / 1000000;
    localparam int MILLI_SCALE    = 1000;

    // Timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int TICK_TIME_NS    = 1000000;
    localparam int TICK_CYCLES     = TICK_TIME_NS / CLOCK_PERIOD_NS;
    localparam int RELEASE_STEP_MS = 5;
    localparam int DIV_BITS        = 48;

endpackage

// file: pst_stage_timing.sv
`timescale 1ns/100ps
`default_nettype none

module pst_stage_timing #(
    parameter int TICK_CYCLES = pst_pkg::TICK_CYCLES,
    parameter int MAG_W       = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    // Pick-up element
    input  wire logic             pickUp,
    input  wire logic [MAG_W-1:0] measMag,
    // Stage outputs
    output var  logic             stageStart,
    output var  logic             stageTrip,
    output var  logic             stageBlocked,
    output var  logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    pst_pkg::pst_ctrl_s ctrl;
    logic [15:0]        timeDial;
    logic [15:0]        pickSet;
    logic [15:0]        releaseSteps;
    pst_pkg::pst_irq_s  irqStat;
    pst_pkg::pst_irq_s  irqMask;
    logic [31:0]        opDelay;
    logic [31:0]        opCount;
    logic [31:0]        relCount;
    logic               releasing;
    logic               pickPrev;
    logic [31:0]        tickCount;
    logic               tick;

    typedef enum logic {DIV_IDLE, DIV_RUN} pst_div_e;
    pst_div_e           divState;
    logic [47:0]        divQuot;
    logic [26:0]        divRem;
    logic [25:0]        divDen;
    logic [5:0]         divIdx;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire logic access   = psel & penable & ~pready;
    wire logic doWrite  = psel & penable & pready & pwrite;
    wire logic hitCtrl  = (paddr == pst_pkg::CTRL_OFFSET);
    wire logic hitDial  = (paddr == pst_pkg::TIMEDIAL_OFFSET);
    wire logic hitPick  = (paddr == pst_pkg::PICKUP_OFFSET);
    wire logic hitRel   = (paddr == pst_pkg::RELEASE_OFFSET);
    wire logic hitStat  = (paddr == pst_pkg::STATUS_OFFSET);
    wire logic hitDelay = (paddr == pst_pkg::DELAY_OFFSET);
    wire logic hitCount = (paddr == pst_pkg::COUNT_OFFSET);
    wire logic hitIrq   = (paddr == pst_pkg::IRQ_STAT_OFFSET);
    wire logic hitMask  = (paddr == pst_pkg::IRQ_MASK_OFFSET);
    wire logic mapped   = hitCtrl | hitDial | hitPick | hitRel | hitStat | hitDelay | hitCount | hitIrq | hitMask;
    wire logic irqRead  = access & ~pwrite & hitIrq;

    wire logic [31:0] readMux =
        hitCtrl  ? {25'h0000000, ctrl} :
        hitDial  ? {16'h0000, timeDial} :
        hitPick  ? {16'h0000, pickSet} :
        hitRel   ? {16'h0000, releaseSteps} :
        hitStat  ? {28'h0000000, releasing, stageBlocked, stageTrip, stageStart} :
        hitDelay ? opDelay :
        hitCount ? opCount :
        hitIrq   ? {29'h00000000, irqStat} :
        hitMask  ? {29'h00000000, irqMask} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Delay computation
    function automatic logic [13:0] lg2q8(input logic [47:0] x);
        logic [5:0]  pos;
        logic [47:0] norm;
        pos = 6'h00;
        for (int i = 0; i < 48; i++) begin
            if (x[i]) begin
                pos = 6'(i);
            end
        end
        norm = x << (6'd47 - pos);
        return {pos, norm[46:39]};
    endfunction

    wire logic [31:0] dialMag  = timeDial * measMag;
    wire logic [47:0] mechNum  = 48'(dialMag) * 48'(pst_pkg::MILLI_SCALE);
    wire logic signed [27:0] mechDen = 28'(pst_pkg::MECH_A_MILLI) * $signed({12'h000, measMag})
                                     - 28'(pst_pkg::MECH_B_MILLI) * $signed({12'h000, pickSet});
    wire logic [47:0] logNum   = 48'(measMag) * 48'(pst_pkg::MILLI_SCALE);
    wire logic [47:0] logDen   = 48'(timeDial) * 48'(pickSet);
    wire logic signed [15:0] logDiff = $signed({2'b00, lg2q8(logNum)}) - $signed({2'b00, lg2q8(logDen)});
    wire logic signed [31:0] logProd = 32'(logDiff) * 32'(pst_pkg::LOG_SLOPE_Q8);
    wire logic signed [31:0] logMs   = 32'(pst_pkg::LOG_A_MS) - (logProd >>> 8);
    wire logic [31:0] logDelay = logMs[31] ? 32'h00000000 : logMs;
    wire logic [26:0] remShift = {divRem[25:0], divQuot[47]};
    wire logic        remFits  = (remShift >= {1'b0, divDen});

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            divState <= DIV_IDLE;
            divQuot  <= 48'h000000000000;
            divRem   <= 27'h0000000;
            divDen   <= 26'h0000000;
            divIdx   <= 6'h00;
            opDelay  <= 32'h00000000;
        end else if (divState == DIV_IDLE) begin
            if (ctrl.curveLog) begin
                opDelay <= logDelay;
            end else if (mechDen <= 0) begin
                opDelay <= 32'hFFFFFFFF;
            end else begin
                divState <= DIV_RUN;
                divQuot  <= mechNum;
                divRem   <= 27'h0000000;
                divDen   <= mechDen[25:0];
                divIdx   <= 6'h00;
            end
        end else begin
            divRem  <= remFits ? (remShift - {1'b0, divDen}) : remShift;
            divQuot <= {divQuot[46:0], remFits};
            divIdx  <= divIdx + 6'h01;
            if (divIdx == 6'(pst_pkg::DIV_BITS - 1)) begin
                divState <= DIV_IDLE;
                opDelay  <= (|divQuot[46:31]) ? 32'hFFFFFFFF : {divQuot[30:0], remFits};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    assign tick = (tickCount == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tickCount <= 32'h00000000;
        end else begin
            tickCount <= tick ? 32'h00000000 : tickCount + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage timing
    // release length in ms
    wire logic [31:0] relLen     = 32'(releaseSteps) * 32'(pst_pkg::RELEASE_STEP_MS);
    wire logic        dropEdge   = pickPrev & ~pickUp;
    wire logic        forceBlock = ctrl.forceEnable & (ctrl.forceState == pst_pkg::FORCE_BLOCKED);
    wire logic        relDone    = releasing & ~pickUp & tick & (relCount + 32'h00000001 >= relLen);
    wire logic        measTrip   = pickUp & (opCount >= opDelay);
    // start held during release when delayed
    wire logic        measStart  = pickUp | ((releasing | dropEdge) & ctrl.delayedRelease);
    wire logic        frcStart   = ctrl.forceEnable & (ctrl.forceState == pst_pkg::FORCE_START
                                                     || ctrl.forceState == pst_pkg::FORCE_TRIP);
    wire logic        frcTrip    = ctrl.forceEnable & (ctrl.forceState == pst_pkg::FORCE_TRIP);
    wire logic        next_start = ~forceBlock & (measStart | frcStart);
    wire logic        next_trip  = ~forceBlock & (measTrip | frcTrip);
    logic [31:0]      next_opCount;
    logic [31:0]      next_relCount;
    logic             next_releasing;

    always_comb begin
        next_opCount   = opCount;
        next_relCount  = relCount;
        next_releasing = releasing;
        if (forceBlock) begin
            next_opCount   = 32'h00000000;
            next_relCount  = 32'h00000000;
            next_releasing = 1'b0;
        end else if (pickUp) begin
            next_releasing = 1'b0;
            next_relCount  = 32'h00000000;
            if (tick && opCount != 32'hFFFFFFFF) begin
                next_opCount = opCount + 32'h00000001;
            end
        end else if (dropEdge) begin
            next_releasing = 1'b1;
            if (!ctrl.resetAfterRelease) begin
                next_opCount = 32'h00000000;
            end
        end else if (relDone) begin
            next_releasing = 1'b0;
            next_relCount  = 32'h00000000;
            next_opCount   = 32'h00000000;
        end else if (releasing && tick) begin
            next_relCount = relCount + 32'h00000001;
            if (ctrl.continueCalc && ctrl.resetAfterRelease && opCount != 32'h00000000) begin
                next_opCount = opCount - 32'h00000001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            opCount      <= 32'h00000000;
            relCount     <= 32'h00000000;
            releasing    <= 1'b0;
            pickPrev     <= 1'b0;
            stageStart   <= 1'b0;
            stageTrip    <= 1'b0;
            stageBlocked <= 1'b0;
        end else begin
            opCount      <= next_opCount;
            relCount     <= next_relCount;
            releasing    <= next_releasing;
            pickPrev     <= pickUp;
            stageStart   <= next_start;
            stageTrip    <= next_trip;
            stageBlocked <= forceBlock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file, APB answer and interrupt
    wire pst_pkg::pst_irq_s irqEvent = '{releaseEnd: relDone,
                                         tripRise:   next_trip & ~stageTrip,
                                         startRise:  next_start & ~stageStart};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl         <= pst_pkg::CTRL_RESET;
            timeDial     <= pst_pkg::TIMEDIAL_RESET;
            pickSet      <= pst_pkg::PICKUP_RESET;
            releaseSteps <= pst_pkg::RELEASE_RESET;
            irqMask      <= pst_pkg::IRQ_MASK_RESET;
            irqStat      <= 3'h0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h00000000;
            irq          <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= (access & ~pwrite) ? readMux : 32'h00000000;
            if (doWrite && hitCtrl) begin
                ctrl <= pwdata[6:0];
            end
            if (doWrite && hitDial) begin
                timeDial <= pwdata[15:0];
            end
            if (doWrite && hitPick) begin
                pickSet <= pwdata[15:0];
            end
            if (doWrite && hitRel) begin
                releaseSteps <= pwdata[15:0];
            end
            if (doWrite && hitMask) begin
                irqMask <= pwdata[2:0];
            end
            irqStat <= (irqRead ? 3'h0 : irqStat) | irqEvent;
            irq     <= |(((irqRead ? 3'h0 : irqStat) | irqEvent) & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_trip_needs_pick;
        @(posedge clock) disable iff (!rst_b)
        (stageTrip && !$past(frcTrip)) |-> $past(pickUp);
    endproperty
    a_trip_needs_pick: assert property (p_trip_needs_pick) else $error("trip without pick-up");

    property p_start_instant;
        @(posedge clock) disable iff (!rst_b)
        (dropEdge && !ctrl.delayedRelease && !ctrl.forceEnable) |=> !stageStart;
    endproperty
    a_start_instant: assert property (p_start_instant) else $error("start not dropped at once");

    property p_start_held;
        @(posedge clock) disable iff (!rst_b)
        (releasing && ctrl.delayedRelease && !forceBlock) |=> stageStart;
    endproperty
    a_start_held: assert property (p_start_held) else $error("start not held in release");

    property p_clear_at_drop;
        @(posedge clock) disable iff (!rst_b)
        (dropEdge && !ctrl.resetAfterRelease) |=> (opCount == 32'h00000000);
    endproperty
    a_clear_at_drop: assert property (p_clear_at_drop) else $error("count not cleared at drop");

    property p_frozen;
        @(posedge clock) disable iff (!rst_b)
        (releasing && !pickUp && !relDone && !forceBlock && ctrl.resetAfterRelease && !ctrl.continueCalc)
        |=> (opCount == $past(opCount));
    endproperty
    a_frozen: assert property (p_frozen) else $error("count moved while frozen");

    property p_decrease;
        @(posedge clock) disable iff (!rst_b)
        (releasing && !pickUp && tick && !relDone && !forceBlock && ctrl.resetAfterRelease
         && ctrl.continueCalc && opCount != 0) |=> (opCount == $past(opCount) - 1);
    endproperty
    a_decrease: assert property (p_decrease) else $error("count not decreased in release");

    property p_clear_after_release;
        @(posedge clock) disable iff (!rst_b)
        relDone |=> (!releasing && opCount == 32'h00000000);
    endproperty
    a_clear_after_release: assert property (p_clear_after_release) else $error("count kept after release");

    property p_trip_at_delay;
        @(posedge clock) disable iff (!rst_b)
        (pickUp && opCount >= opDelay && !forceBlock) |=> stageTrip;
    endproperty
    a_trip_at_delay: assert property (p_trip_at_delay) else $error("no trip at delay");

    property p_log_instant;
        @(posedge clock) disable iff (!rst_b)
        (divState == DIV_IDLE && ctrl.curveLog && logMs < 0) |=> (opDelay == 32'h00000000);
    endproperty
    a_log_instant: assert property (p_log_instant) else $error("negative delay not instant");

    property p_force_trip;
        @(posedge clock) disable iff (!rst_b)
        (ctrl.forceEnable && ctrl.forceState == pst_pkg::FORCE_TRIP) |=> (stageTrip && stageStart);
    endproperty
    a_force_trip: assert property (p_force_trip) else $error("forced trip not shown");

    property p_measured_while_forced;
        @(posedge clock) disable iff (!rst_b)
        (ctrl.forceEnable && ctrl.forceState == pst_pkg::FORCE_NORMAL && pickUp) |=> stageStart;
    endproperty
    a_measured_while_forced: assert property (p_measured_while_forced) else $error("pick-up ignored");

endmodule
`default_nettype wire

// file: pst_pickup_model.sv
`timescale 1ns/100ps
`default_nettype none

module pst_pickup_model #(
    parameter int          MAG_W     = 16,
    parameter logic [15:0] THRESHOLD = 16'h0064
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Magnitude set by the bench
    input  wire logic [MAG_W-1:0] level,
    // Towards the stage
    output var  logic             pickUp,
    output var  logic [MAG_W-1:0] measMag
);
    assign measMag = level;

    // Comparator output is registered, as the real element is
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pickUp <= 1'b0;
        end else begin
            pickUp <= (level >= THRESHOLD);
        end
    end
endmodule

`default_nettype wire

// file: protection_stage_release_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none

module protection_stage_release_timing_tb;
    localparam int TICK = 4;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pickUp;
    logic [15:0] measMag;
    logic [15:0] mag = 16'h0000;
    logic        stageStart;
    logic        stageTrip;
    logic        stageBlocked;
    logic        irq;
    logic [31:0] rdv;
    logic [31:0] c1;
    logic        err;
    int          n_mismatch = 0;
    int          compares = 0;

    always #12.5 clock = ~clock;

    pst_stage_timing #(.TICK_CYCLES(TICK), .MAG_W(16)) uut (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pickUp(pickUp), .measMag(measMag), .stageStart(stageStart), .stageTrip(stageTrip),
        .stageBlocked(stageBlocked), .irq(irq));

    pst_pickup_model #(.MAG_W(16), .THRESHOLD(16'h0064)) partner (
        .clock(clock), .rst_b(rst_b), .level(mag), .pickUp(pickUp), .measMag(measMag));

    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h00000001);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic pulse(input int ticks);
        mag <= 16'h00C8;
        idle(ticks * TICK);
        mag <= 16'h0000;
        idle(3);
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs;
        apb(1'b0, pst_pkg::CTRL_OFFSET, 32'h0);
        chk(rdv, 32'h00000003);
        apb(1'b0, pst_pkg::TIMEDIAL_OFFSET, 32'h0);
        chk(rdv, 32'h000003E8);
        apb(1'b0, pst_pkg::PICKUP_OFFSET, 32'h0);
        chk(rdv, 32'h00000064);
        apb(1'b0, pst_pkg::RELEASE_OFFSET, 32'h0);
        chk(rdv, 32'h0000000C);
        apb(1'b0, pst_pkg::IRQ_MASK_OFFSET, 32'h0);
        chk(rdv, 32'h00000000);
        chk({31'h0, err}, 32'h00000000);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h00000001);
        chk(rdv, 32'h00000000);
        $display("test regs done");
    endtask

    task automatic test_trip;
        apb(1'b1, pst_pkg::TIMEDIAL_OFFSET, 32'h0000000A);
        apb(1'b1, pst_pkg::RELEASE_OFFSET, 32'h00000004);
        mag <= 16'h00C8;
        idle(60);
        apb(1'b0, pst_pkg::DELAY_OFFSET, 32'h0);
        chk(rdv, 32'h0000002D);
        chk({31'h0, stageStart}, 32'h1);
        chk({31'h0, stageTrip}, 32'h0);
        for (int n = 0; n < 400 && stageTrip !== 1'b1; n++) @(posedge clock);
        chk({31'h0, stageTrip}, 32'h1);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        chk({31'h0, rdv >= 32'h2D}, 32'h1);
        mag <= 16'h0000;
        idle(3);
        chk({31'h0, stageTrip}, 32'h0);
        chk({31'h0, stageStart}, 32'h1);
        idle(57);
        chk({31'h0, stageStart}, 32'h1);
        idle(40);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, stageStart}, 32'h0);
        $display("test trip done");
    endtask

    task automatic test_modes;
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000001);
        pulse(20);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, stageStart}, 32'h1);
        idle(100);
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000003);
        pulse(20);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        c1 = rdv;
        idle(20);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        chk(rdv, c1);
        chk({31'h0, c1 != 32'h0}, 32'h1);
        idle(100);
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000007);
        pulse(40);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        c1 = rdv;
        idle(40);
        apb(1'b0, pst_pkg::COUNT_OFFSET, 32'h0);
        chk({31'h0, rdv < c1}, 32'h1);
        idle(100);
        chk({31'h0, stageTrip}, 32'h0);
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000000);
        pulse(5);
        chk({31'h0, stageStart}, 32'h0);
        idle(100);
        $display("test modes done");
    endtask

    task automatic test_log;
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h0000000B);
        apb(1'b1, pst_pkg::TIMEDIAL_OFFSET, 32'h00000001);
        mag <= 16'h03E8;
        idle(60);
        apb(1'b0, pst_pkg::DELAY_OFFSET, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, stageTrip}, 32'h1);
        apb(1'b1, pst_pkg::TIMEDIAL_OFFSET, 32'h000003E8);
        mag <= 16'h00C8;
        idle(2);
        apb(1'b0, pst_pkg::DELAY_OFFSET, 32'h0);
        chk({31'h0, rdv >= 32'h000012FC && rdv <= 32'h00001306}, 32'h1);
        mag <= 16'h0000;
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000003);
        apb(1'b1, pst_pkg::TIMEDIAL_OFFSET, 32'h0000000A);
        idle(100);
        $display("test log done");
    endtask

    task automatic test_force;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000013 | (s << 5));
            idle(3);
            chk({31'h0, stageTrip}, {31'h0, s == 2});
            chk({31'h0, stageBlocked}, {31'h0, s == 3});
            if (s == 1) chk({31'h0, stageStart}, 32'h1);
            apb(1'b0, pst_pkg::STATUS_OFFSET, 32'h0);
            chk(rdv, {28'h0, 1'b0, s == 3, s == 2, s == 1 || s == 2});
        end
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000013);
        mag <= 16'h00C8;
        idle(4);
        chk({31'h0, stageStart}, 32'h1);
        mag <= 16'h0000;
        apb(1'b1, pst_pkg::CTRL_OFFSET, 32'h00000003);
        idle(100);
        $display("test force done");
    endtask

    task automatic test_irq;
        apb(1'b0, pst_pkg::IRQ_STAT_OFFSET, 32'h0);
        mag <= 16'h00C8;
        idle(4);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, pst_pkg::IRQ_MASK_OFFSET, 32'h00000001);
        idle(2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, pst_pkg::IRQ_STAT_OFFSET, 32'h0);
        chk(rdv & 32'h1, 32'h1);
        idle(2);
        chk({31'h0, irq}, 32'h0);
        mag <= 16'h0000;
        idle(100);
        apb(1'b0, pst_pkg::IRQ_STAT_OFFSET, 32'h0);
        chk(rdv & 32'h4, 32'h4);
        $display("test irq done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        idle(5);
        rst_b <= 1'b1;
        test_regs();
        test_trip();
        test_modes();
        test_log();
        test_force();
        test_irq();
        complete_run();
    end

    initial begin
        idle(20000);
        n_mismatch++;
        complete_run();
    end
endmodule

`default_nettype wire
